// ---- rtl/dhp_fifo.sv ----
`timescale 1ns/1ps
module dhp_fifo
  import dhp_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dhp_fifo_state_type;

  dhp_fifo_state_type q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) d.wp = q.wp + 1'b1;
    if (pop) d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) d = '0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage
  always_ff @(posedge core_clk) begin
    if (push) mem[q.wp] <= in_data;
  end
endmodule

// ---- rtl/dhp_pkg.sv ----
//------------------------------------------------------------
// constants of the disk controller host and dma port
//------------------------------------------------------------
// Contract
// - slow dma partner sets transfer lag flag, bit 1 of register 05
// - after transfer lag, operation ends when current sector completes
// - after stop, finish current sector, then halt; no more dma requests
// - write ended by stop pads the sector with last received byte
// - stop is ignored unless acknowledge is low in the same cycle
// - port select low: pointer or status; high: indirect registers
// - direction low writes, high reads; honoured only while chip select low
// - all processor and dma accesses sync to buffer clock rising edge
// - first general status input reads as bit 6 of register 04
// - second general status input reads as bit 7 of register 04
// - index rising edge marks track start, once per revolution
// - hard sectored: sector input edge starts sectors, index starts sector 0
// - esdi mode: address mark found edge starts sectors, index sector 0
// - seek complete / serial status / lower tape hole in status bit 2
// - track zero / transfer ack / upper tape hole in status bit 1
// - request goes low while a byte is ready or a byte is needed
// - on acknowledge, drive a byte on disk reads, capture on writes
package dhp_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SEC_LEN_W = 16;
  localparam logic [7:0] REG_GEN_STATUS = 8'h04;
  localparam logic [7:0] REG_ERROR = 8'h05;
  localparam int ERR_LAG_BIT = 1;
  localparam int GEN_ST0_BIT = 6;
  localparam int GEN_ST1_BIT = 7;
  localparam int STAT_SEEK_BIT = 2;
  localparam int STAT_TRK_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_XFER} dhp_phase_type;
endpackage

// ---- rtl/dhp_port.sv ----
`timescale 1ns/1ps
module dhp_port
  import dhp_pkg::*;
(
  // buffer clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // processor port
  input wire logic register_chip_select_n,
  input wire logic write_not_read_line,
  input wire logic port_select_line,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // indirect registers of the rest of the chip
  output logic [7:0] reg_addr,
  output logic reg_wr_pulse,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  // dma handshake
  output logic request_n,
  input wire logic acknowledge_n,
  input wire logic stop_n,
  // drive status and timing
  input wire logic index_in,
  input wire logic sector_in,
  input wire logic gen_status0,
  input wire logic gen_status1,
  input wire logic seek_status,
  input wire logic track_status,
  // operation control
  input wire logic esdi_mode,
  input wire logic op_start,
  input wire logic op_write,
  input wire logic [SEC_LEN_W-1:0] sector_len_m1,
  output logic busy,
  output logic xfer_lag,
  // medium byte stream
  input wire logic med_tick,
  input wire logic [7:0] med_rd_data,
  output logic [7:0] med_wr_data,
  output logic med_wr_valid
);
  typedef struct packed {
    dhp_phase_type ph;
    logic [7:0] ptr;
    logic [7:0] rd;
    logic wr_pls;
    logic [7:0] wr_data;
    logic is_wr;
    logic lag;
    logic stop;
    logic [SEC_LEN_W-1:0] cnt;
    logic hold;
    logic [7:0] hold_byte;
    logic [7:0] last;
    logic [7:0] med_out;
    logic med_vld;
  } dhp_port_state_type;

  dhp_port_state_type q, d;

  //------------------------------------------------------------
  // sector boundary edges
  //------------------------------------------------------------
  logic idx_rise, sec_rise, am_rise, sec_start;

  dhp_rise u_idx (
    .core_clk(core_clk),
    .srst(srst),
    .lvl(index_in),
    .rise(idx_rise)
  );

  dhp_rise u_sec (
    .core_clk(core_clk),
    .srst(srst),
    .lvl(sector_in & ~esdi_mode),
    .rise(sec_rise)
  );

  dhp_rise u_am (
    .core_clk(core_clk),
    .srst(srst),
    .lvl(sector_in & esdi_mode),
    .rise(am_rise)
  );

  // index starts sector 0, the mode's edge starts the rest
  assign sec_start = idx_rise | sec_rise | am_rise;

  //------------------------------------------------------------
  // data fifo between medium and dma
  //------------------------------------------------------------
  logic active, xfer_tick, ack, ack_rd, ack_wr, sec_end;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_in_data, f_out_data;
  logic hold_load, want;

  assign active = (q.ph != ST_IDLE);
  assign xfer_tick = (q.ph == ST_XFER) & med_tick;
  assign ack = ~acknowledge_n & active;
  assign ack_rd = ack & ~q.is_wr;
  assign ack_wr = ack & q.is_wr;
  assign sec_end = xfer_tick & (q.cnt == sector_len_m1);

  // reads fill from medium, writes fill from dma
  assign f_in_valid = q.is_wr ? ack_wr : xfer_tick;
  assign f_in_data = q.is_wr ? data_in : med_rd_data;
  assign hold_load = active & ~q.is_wr & ~q.hold & f_out_valid;
  assign f_out_ready = q.is_wr ? xfer_tick : (active & ~q.hold);

  dhp_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .flush(op_start & ~active),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  //------------------------------------------------------------
  // read values
  //------------------------------------------------------------
  logic [7:0] stat_val, ind_val;

  // status register
  always_comb begin
    stat_val = 8'h00;
    stat_val[STAT_SEEK_BIT] = seek_status;
    stat_val[STAT_TRK_BIT] = track_status;
    stat_val[STAT_BUSY_BIT] = active;
  end

  // indirectly selected read registers
  always_comb begin
    ind_val = reg_rd_data;
    if (q.ptr == REG_GEN_STATUS) begin
      ind_val = 8'h00;
      ind_val[GEN_ST0_BIT] = gen_status0;
      ind_val[GEN_ST1_BIT] = gen_status1;
    end else if (q.ptr == REG_ERROR) begin
      ind_val = 8'h00;
      ind_val[ERR_LAG_BIT] = q.lag;
    end
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    d = q;
    d.wr_pls = 1'b0;
    d.med_vld = 1'b0;
    // processor access, only while selected
    if (~register_chip_select_n) begin
      if (~write_not_read_line) begin
        if (~port_select_line) begin
          d.ptr = data_in;
        end else begin
          d.wr_pls = 1'b1;
          d.wr_data = data_in;
        end
      end else begin
        d.rd = port_select_line ? ind_val : stat_val;
      end
    end
    // stop counts only with acknowledge
    if (ack & ~stop_n) d.stop = 1'b1;
    // one acknowledge moves one byte
    if (ack_wr) d.last = data_in;
    if (ack_rd) d.hold = 1'b0;
    if (hold_load) begin
      d.hold = 1'b1;
      d.hold_byte = f_out_data;
    end
    // medium byte time
    if (xfer_tick) begin
      d.cnt = q.cnt + 1'b1;
      if (q.is_wr) begin
        d.med_vld = 1'b1;
        d.med_out = f_out_valid ? f_out_data : q.last;
        if (~f_out_valid & ~q.stop) d.lag = 1'b1;
      end else if (~f_in_ready & ~q.stop) begin
        d.lag = 1'b1;
      end
    end
    case (q.ph)
      ST_IDLE: begin
        if (op_start) begin
          d.ph = ST_WAIT;
          d.is_wr = op_write;
          d.lag = 1'b0;
          d.stop = 1'b0;
          d.hold = 1'b0;
          d.cnt = '0;
        end
      end
      ST_WAIT: begin
        if (sec_start) begin
          d.ph = ST_XFER;
          d.cnt = '0;
        end
      end
      ST_XFER: begin
        // sector done: halt on stop or lag, else wait next sector
        if (sec_end) begin
          d.cnt = '0;
          d.ph = (d.stop | d.lag) ? ST_IDLE : ST_WAIT;
        end
      end
      default: d.ph = ST_IDLE;
    endcase
  end

  // all state moves on the buffer clock rising edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.ph <= ST_IDLE;
      q.ptr <= PTR_RST;
      q.rd <= BYTE_RST;
    end else begin
      q <= d;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // request while a byte waits or space exists, never after stop
  assign want = active & (q.is_wr ? f_in_ready : q.hold);
  assign request_n = ~(want & ~q.stop & acknowledge_n);

  // dma read byte has priority on the data lines
  assign data_out = ack_rd ? q.hold_byte : q.rd;
  assign data_oe = ack_rd | (~register_chip_select_n & write_not_read_line);

  assign reg_addr = q.ptr;
  assign reg_wr_pulse = q.wr_pls;
  assign reg_wr_data = q.wr_data;
  assign busy = active;
  assign xfer_lag = q.lag;
  assign med_wr_data = q.med_out;
  assign med_wr_valid = q.med_vld;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  read_lag_a: assert property (
    xfer_tick && !q.is_wr && !f_in_ready && !q.stop |=> q.lag && (q.ptr != REG_ERROR || ind_val == 8'h02)
  ) else $error("overrun did not set lag flag");

  lag_halt_a: assert property (
    q.lag && sec_end |=> q.ph == ST_IDLE && !busy
  ) else $error("lag did not halt at sector end");

  stop_quiet_a: assert property (
    q.stop |-> request_n
  ) else $error("request after stop");

  pad_byte_a: assert property (
    xfer_tick && q.is_wr && !f_out_valid |=> med_wr_valid && med_wr_data == $past(q.last)
  ) else $error("write pad byte wrong");

  stop_gate_a: assert property (
    active && acknowledge_n && !q.stop |=> !q.stop
  ) else $error("stop taken without acknowledge");

  ptr_load_a: assert property (
    !register_chip_select_n && !write_not_read_line && !port_select_line |=> reg_addr == $past(data_in)
  ) else $error("pointer not loaded");

  desel_a: assert property (
    register_chip_select_n ##1 1 |-> !reg_wr_pulse && reg_addr == $past(reg_addr)
  ) else $error("access while deselected");

  gen_status_a: assert property (
    !register_chip_select_n && write_not_read_line && port_select_line && q.ptr == REG_GEN_STATUS
    |=> q.rd == {$past(gen_status1), $past(gen_status0), 6'h00}
  ) else $error("general status read wrong");

  drive_status_a: assert property (
    !register_chip_select_n && write_not_read_line && !port_select_line
    |=> q.rd[2:1] == {$past(seek_status), $past(track_status)}
  ) else $error("drive status read wrong");

  sector_go_a: assert property (
    q.ph == ST_WAIT && sec_start |=> q.ph == ST_XFER && q.cnt == '0
  ) else $error("sector start missed");

  dma_drive_a: assert property (
    ack_rd |-> data_oe && data_out == q.hold_byte ##1 !q.hold || hold_load
  ) else $error("dma read byte not driven");

  rd_req_a: assert property (
    active && !q.is_wr && q.hold && !q.stop && acknowledge_n |-> !request_n
  ) else $error("held byte not requested");

  // register port direction
  oe_dir_a: assert property (
    register_chip_select_n && !ack_rd |-> !data_oe ##1 q.rd == $past(q.rd)
  ) else $error("lines driven while deselected");

  // dma write capture
  wr_capture_a: assert property (
    ack_wr |=> q.last == $past(data_in)
  ) else $error("write byte not captured");

  // sector start edges per mode
  hard_sector_a: assert property (
    q.ph == ST_WAIT && !esdi_mode && sector_in && !$past(sector_in)
    |=> q.ph == ST_XFER
  ) else $error("sector pulse missed");

  esdi_sector_a: assert property (
    q.ph == ST_WAIT && esdi_mode && sector_in && !$past(sector_in)
    |=> q.ph == ST_XFER
  ) else $error("address mark missed");

  // operation end
  stop_halt_a: assert property (
    q.stop && sec_end |=> !busy
  ) else $error("stop did not halt at sector end");

  lag_sticky_a: assert property (
    q.lag && active |=> q.lag
  ) else $error("lag flag lost during operation");

  read_sector_c: cover property (q.ph == ST_XFER && !q.is_wr ##[1:300] sec_end);
  write_pad_c: cover property (q.is_wr && q.stop ##[1:300] xfer_tick && !f_out_valid);
  lag_c: cover property (!q.lag ##1 q.lag);
  fifo_full_c: cover property (active && !f_in_ready);
  am_start_c: cover property (q.ph == ST_WAIT && am_rise);
endmodule

// ---- rtl/dhp_rise.sv ----
`timescale 1ns/1ps
module dhp_rise
  import dhp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // level in, edge out
  input wire logic lvl,
  output logic rise
);
  typedef struct packed {
    logic prev;
  } dhp_rise_state_type;

  dhp_rise_state_type q, d;

  // remember last level
  always_comb begin
    d = q;
    d.prev = lvl;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = lvl & ~q.prev;
endmodule

// ---- sim/dhp_dma_model.sv ----
`timescale 1ns/1ps
// dma partner: answers each request with a one-cycle acknowledge
module dhp_dma_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // behaviour control
  input wire logic en,
  input wire logic glitch,
  input wire logic [7:0] stop_at,
  input wire logic [7:0] delay,
  // handshake
  input wire logic request_n,
  output logic acknowledge_n,
  output logic stop_n,
  output logic [7:0] dma_data,
  output logic [7:0] cnt
);
  logic req_seen;
  logic [7:0] wait_cnt;

  // request sampled on the edge, answer lands while the clock is high
  always @(posedge core_clk) begin
    req_seen = !request_n;
    #1;
    if (srst || !en) begin
      acknowledge_n = 1'b1;
      stop_n = 1'b1;
      cnt = 8'h00;
      wait_cnt = 8'h00;
      if (srst) dma_data = 8'h00;
    end else if (!acknowledge_n) begin
      acknowledge_n = 1'b1;
      stop_n = 1'b1;
      dma_data = ~dma_data;
    end else if (req_seen && wait_cnt >= delay) begin
      acknowledge_n = 1'b0;
      dma_data = 8'($urandom);
      cnt = cnt + 8'h01;
      stop_n = !(cnt == stop_at);
      wait_cnt = 8'h00;
    end else begin
      wait_cnt = wait_cnt + 8'h01;
      stop_n = !(glitch && cnt < stop_at); // stray stop without acknowledge
    end
  end
endmodule

// ---- sim/tb_dhp_port.sv ----
`timescale 1ns/1ps
module tb_dhp_port
  import dhp_pkg::*;
;
  logic core_clk = 1'b0, srst = 1'b1, cs_n = 1'b1, wnr = 1'b1, ps = 1'b0;
  logic [7:0] cpu_d = 8'h00, reg_rd_data = 8'h00, med_rd_data = 8'h00, stop_at = 8'h00, delay = 8'h00;
  logic index_in = 1'b0, sector_in = 1'b0, gst0 = 1'b0, gst1 = 1'b0, seek = 1'b0, trk = 1'b0;
  logic esdi = 1'b0, op_start = 1'b0, op_write = 1'b0, med_tick = 1'b0, en = 1'b0, glitch = 1'b0;
  logic [SEC_LEN_W-1:0] len_m1 = 16'h0007;
  logic [7:0] data_out, reg_addr, reg_wr_data, med_wr_data, dma_data, cnt, data_in, q, a, v, wd;
  logic data_oe, reg_wr_pulse, request_n, acknowledge_n, stop_n, busy, xfer_lag, med_wr_valid, wp;
  logic [7:0] mq[$], rq[$], wq[$], dq[$];
  int num_errors = 0;
  int total_checks = 0;
  int oe_miss = 0;

  // data lines: dma byte during acknowledge, processor byte otherwise
  assign data_in = acknowledge_n ? cpu_d : dma_data;

  always #25 core_clk = ~core_clk;

  dhp_port dut (.core_clk(core_clk), .srst(srst), .register_chip_select_n(cs_n), .write_not_read_line(wnr),
    .port_select_line(ps), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .reg_addr(reg_addr),
    .reg_wr_pulse(reg_wr_pulse), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .request_n(request_n),
    .acknowledge_n(acknowledge_n), .stop_n(stop_n), .index_in(index_in), .sector_in(sector_in),
    .gen_status0(gst0), .gen_status1(gst1), .seek_status(seek), .track_status(trk), .esdi_mode(esdi),
    .op_start(op_start), .op_write(op_write), .sector_len_m1(len_m1), .busy(busy), .xfer_lag(xfer_lag),
    .med_tick(med_tick), .med_rd_data(med_rd_data), .med_wr_data(med_wr_data), .med_wr_valid(med_wr_valid));

  dhp_dma_model p_dma (.core_clk(core_clk), .srst(srst), .en(en), .glitch(glitch), .stop_at(stop_at),
    .delay(delay), .request_n(request_n), .acknowledge_n(acknowledge_n), .stop_n(stop_n),
    .dma_data(dma_data), .cnt(cnt));

  // collect dma bytes and medium write bytes
  always @(posedge core_clk) begin
    if (!acknowledge_n && busy) begin
      if (op_write) dq.push_back(data_in);
      else begin
        rq.push_back(data_out);
        if (!data_oe) oe_miss++;
      end
    end
    if (med_wr_valid) wq.push_back(med_wr_data);
  end

  //------------------------------------------------------------
  // tasks
  //------------------------------------------------------------
  task cyc;
    @(posedge core_clk);
    #1;
  endtask

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h got %h", name, exp, got);
    end
  endtask

  // expected register 04 byte from the two general status levels
  function automatic logic [7:0] exp_gen(input logic s1, input logic s0);
    return {s1, s0, 6'h00};
  endfunction

  // expected status byte: seek bit 2, track bit 1, busy bit 0
  function automatic logic [7:0] exp_stat(input logic sk, input logic tk, input logic bz);
    return {5'h00, sk, tk, bz};
  endfunction

  task cpu_wr(input logic p, input logic [7:0] d);
    cs_n = 1'b0;
    wnr = 1'b0;
    ps = p;
    cpu_d = d;
    cyc;
    wp = reg_wr_pulse;
    wd = reg_wr_data;
    cs_n = 1'b1;
    wnr = 1'b1;
    cyc;
  endtask

  task cpu_rd(input logic p, output logic [7:0] r);
    cs_n = 1'b0;
    wnr = 1'b1;
    ps = p;
    cyc;
    r = data_out;
    chk("data_oe", 8'h01, {7'h00, data_oe});
    cyc;
    cs_n = 1'b1;
    cyc;
    chk("oe_off", 8'h00, {7'h00, data_oe});
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc;
    s = 1'b0;
    repeat (4) cyc;
  endtask

  task automatic run_op(input logic wr, input logic use_sec, input logic md, input int n,
                        input logic [7:0] sa, input logic [7:0] dl, input logic gl);
    op_write = wr;
    esdi = md;
    len_m1 = SEC_LEN_W'(n - 1);
    stop_at = sa;
    delay = dl;
    glitch = gl;
    en = 1'b1;
    mq.delete();
    rq.delete();
    wq.delete();
    dq.delete();
    pulse(op_start);
    chk("busy", 8'h01, {7'h00, busy});
    repeat (20) cyc;
    if (use_sec) pulse(sector_in);
    else pulse(index_in);
    for (int i = 0; i < n; i++) begin
      med_rd_data = 8'($urandom);
      mq.push_back(med_rd_data);
      med_tick = 1'b1;
      cyc;
      med_tick = 1'b0;
      repeat (3) cyc;
    end
    chk("busy_end", 8'h00, {7'h00, busy});
  endtask

  task summarize;
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    void'($urandom(67776));
    repeat (3) cyc;
    srst = 1'b0;
    cyc;
    chk("request_n", 8'h01, {7'h00, request_n});
    chk("reg_addr", 8'h00, reg_addr);
    // register port with random status levels
    for (int k = 0; k < 4; k++) begin
      {gst0, gst1, seek, trk} = 4'($urandom);
      reg_rd_data = 8'($urandom);
      a = 8'($urandom_range(255, 6));
      v = 8'($urandom);
      cpu_wr(1'b0, 8'h04);
      chk("reg_addr", 8'h04, reg_addr);
      cpu_rd(1'b1, q);
      chk("reg04", exp_gen(gst1, gst0), q);
      cpu_rd(1'b0, q);
      chk("status", exp_stat(seek, trk, 1'b0), q);
      cpu_wr(1'b0, a);
      cpu_rd(1'b1, q);
      chk("indirect", reg_rd_data, q);
      cpu_wr(1'b1, v);
      chk("wr_pulse", 8'h01, {7'h00, wp});
      chk("wr_data", v, wd);
      wnr = 1'b0;
      ps = 1'b0;
      cpu_d = 8'h04;
      repeat (2) cyc;
      wnr = 1'b1;
      chk("ptr_hold", a, reg_addr);
    end
    // read ended by stop, stray stop levels without acknowledge
    run_op(1'b0, 1'b0, 1'b0, 8, 8'h03, 8'h00, 1'b1);
    chk("acks", 8'h03, cnt);
    chk("rd_count", 8'h03, 8'(rq.size()));
    for (int i = 0; i < 3; i++) chk("rd_byte", mq[i], rq[i]);
    chk("oe_miss", 8'h00, 8'(oe_miss));
    chk("lag", 8'h00, {7'h00, xfer_lag});
    en = 1'b0;
    cyc;
    // write ended by stop, sector padded with the last byte
    run_op(1'b1, 1'b1, 1'b0, 8, 8'h03, 8'h00, 1'b0);
    chk("acks", 8'h03, cnt);
    chk("wr_count", 8'h08, 8'(wq.size()));
    for (int i = 0; i < 8; i++) chk("wr_byte", (i < 3) ? dq[i] : dq[2], wq[i]);
    en = 1'b0;
    cyc;
    // slow partner on an address-mark sector forces the lag flag
    run_op(1'b0, 1'b1, 1'b1, 12, 8'h00, 8'h28, 1'b0);
    chk("lag", 8'h01, {7'h00, xfer_lag});
    en = 1'b0;
    cyc;
    cpu_wr(1'b0, 8'h05);
    cpu_rd(1'b1, q);
    chk("reg05", 8'h02, q);
    summarize;
  end

  // watchdog far beyond the expected run
  initial begin
    #200000;
    num_errors++;
    summarize;
  end
endmodule
